// ### core/srp_cfg.svh
// Constants for the serial register port: address, register map, reset defaults.
// Assumes inclusion by the register file, the port module and the bench.
`ifndef SRP_CFG_SVH
`define SRP_CFG_SVH
`define SRP_ADDR_HI 6'h35
`define SRP_NUM_REGS 6'h30
`define SRP_LAST_REG 6'h2F
`define SRP_FSC_BASE 6'h0E
`define SRP_FSC_CODE 32'h21F07C16
`define SRP_MODE4_IDX 6'h04
`define SRP_PED_BIT 4
`define SRP_PED_RESET 8'h10
`define SRP_CLEAR_VAL 8'h00
`define SRP_STD_IDX 6'h00
`define SRP_STD_NTSC 2'h0
`endif

// ### core/srp_pkg.sv
// Types for the serial register port.
// Assumes srp_cfg.svh sits on the include path.
`default_nettype none
package srp_pkg;
	typedef enum logic [6:0] {
		SRP_IDLE = 7'h01,
		SRP_ADDR = 7'h02,
		SRP_AACK = 7'h04,
		SRP_SUBA = 7'h08,
		SRP_WDAT = 7'h10,
		SRP_RDAT = 7'h20,
		SRP_RACK = 7'h40
	} srp_state_t;
	typedef logic [5:0] srp_idx_t;
	typedef logic [7:0] srp_byte_t;
endpackage
`default_nettype wire

// ### core/srp_regfile.sv
// Register storage for the serial port, 48 bytes, registered read data.
// Assumes one clock; reset loads the documented defaults.
`default_nettype none
`include "srp_cfg.svh"
module srp_regfile (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_we,
	input wire srp_pkg::srp_idx_t i_waddr,
	input wire srp_pkg::srp_byte_t i_wdata,
	input wire srp_pkg::srp_idx_t i_raddr,
	output srp_pkg::srp_byte_t o_rdata,
	output logic o_ped_en,
	output logic [1:0] o_std
);
	import srp_pkg::*;
	srp_byte_t mem_q [0:47]; // Configuration bytes

	// Reset value per index
	function automatic srp_byte_t reset_val(input int idx);
		if (idx == int'(`SRP_MODE4_IDX)) begin
			reset_val = `SRP_PED_RESET;
		end else if (idx >= int'(`SRP_FSC_BASE) && idx < int'(`SRP_FSC_BASE) + 4) begin
			reset_val = 8'(`SRP_FSC_CODE >> (8 * (idx - int'(`SRP_FSC_BASE)))); // Low byte first
		end else begin
			reset_val = `SRP_CLEAR_VAL;
		end
	endfunction

	// One always_ff per byte; reset defaults
	genvar g;
	for (g = 0; g < 48; g++) begin : g_reg
		always_ff @(posedge i_clk) begin
			if (!i_rst_n) begin
				mem_q[g] <= reset_val(g);
			end else if (i_we && i_waddr == srp_idx_t'(g)) begin
				mem_q[g] <= i_wdata;
			end
		end
	end

	// Registered read port and decoded mode outputs
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_rdata <= `SRP_CLEAR_VAL;
			o_ped_en <= 1'b1;
			o_std <= `SRP_STD_NTSC;
		end else begin
			o_rdata <= (i_raddr <= `SRP_LAST_REG) ? mem_q[i_raddr] : `SRP_CLEAR_VAL;
			o_ped_en <= mem_q[`SRP_MODE4_IDX][`SRP_PED_BIT];
			o_std <= mem_q[`SRP_STD_IDX][1:0];
		end
	end
endmodule // srp_regfile
`default_nettype wire

// ### core/srp_port.sv
// Serial slave port: start/stop detect, address match, pointer, bursts.
// Assumes serial lines arrive asynchronous, sampled far faster than bit rate.
`default_nettype none
`include "srp_cfg.svh"
module srp_port (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_serial_clock_line,
	input wire logic i_serial_data_line,
	input wire logic i_address_select_pin,
	output logic o_serial_data_line_oe,
	output logic o_serial_data_line_out,
	output logic o_pedestal_enable,
	output logic [1:0] o_output_standard,
	output logic o_low_pixel_input_byte_sel
);
	import srp_pkg::*;

	logic [1:0] scl_sync_q; // Clock synchroniser
	logic [1:0] sda_sync_q; // Data synchroniser
	logic scl_q; // Previous synced clock
	logic sda_q; // Previous synced data
	logic strap_q; // Captured strap
	logic strap_meta_q; // Strap first stage
	logic addr_phase_q; // Ack in progress follows the address byte
	srp_state_t state_q; // Protocol state
	logic [3:0] bit_cnt_q; // Bits in byte
	srp_byte_t shift_q; // Receive shifter
	srp_byte_t tx_q; // Transmit shifter
	srp_idx_t ptr_q; // Register pointer
	logic rd_q; // Direction latched
	logic we_q; // Regfile write pulse
	srp_byte_t rdata; // Regfile data
	logic ped_en;
	logic [1:0] std_sel;

	wire logic scl = scl_sync_q[1];
	wire logic sda = sda_sync_q[1];
	wire logic scl_rise = scl && !scl_q;
	wire logic scl_fall = !scl && scl_q;
	wire logic start_c = scl && scl_q && sda_q && !sda;
	wire logic stop_c = scl && scl_q && !sda_q && sda;
	wire srp_byte_t rx_byte = {shift_q[6:0], sda};

	// Pointer valid check used in several places
	function automatic logic idx_ok(input srp_byte_t b);
		idx_ok = (b[7:6] == 2'h0) && (b[5:0] <= `SRP_LAST_REG);
	endfunction

	// Two flops before any logic reads the pins
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			scl_sync_q <= 2'h3;
			sda_sync_q <= 2'h3;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_sync_q <= {scl_sync_q[0], i_serial_clock_line};
			sda_sync_q <= {sda_sync_q[0], i_serial_data_line};
			scl_q <= scl;
			sda_q <= sda;
		end
	end

	// Strap caught while reset is held, a clocked sample, not a reset value
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			strap_meta_q <= i_address_select_pin; // First stage, may be metastable
			strap_q <= strap_meta_q;
		end
	end

	// Protocol engine; state updated on synced clock edges and on start/stop
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			state_q <= SRP_IDLE;
			bit_cnt_q <= 4'h0;
			shift_q <= 8'h00;
			rd_q <= 1'b0;
			ptr_q <= 6'h00;
			addr_phase_q <= 1'b0;
			we_q <= 1'b0;
		end else begin
			we_q <= 1'b0;
			if (start_c) begin
				state_q <= SRP_ADDR;
				addr_phase_q <= 1'b0;
				bit_cnt_q <= 4'h0;
			end else if (stop_c) begin
				state_q <= SRP_IDLE;
			end else begin
				case (state_q)
					SRP_ADDR, SRP_SUBA, SRP_WDAT: begin
						if (scl_rise) begin
							shift_q <= rx_byte; // MSB first
							bit_cnt_q <= bit_cnt_q + 4'h1;
							if (bit_cnt_q == 4'h7) begin
								bit_cnt_q <= 4'h0;
								if (state_q == SRP_ADDR) begin
									if (rx_byte[7:1] == {`SRP_ADDR_HI, strap_q}) begin
										rd_q <= rx_byte[0];
										addr_phase_q <= 1'b1;
										state_q <= SRP_AACK;
									end else begin
										state_q <= SRP_IDLE;
									end
								end else if (state_q == SRP_SUBA) begin
									if (idx_ok(rx_byte)) begin
										ptr_q <= rx_byte[5:0];
										state_q <= SRP_AACK;
									end else begin
										state_q <= SRP_IDLE;
									end
								end else if (ptr_q <= `SRP_LAST_REG) begin
									we_q <= 1'b1;
									state_q <= SRP_AACK;
								end else begin
									state_q <= SRP_IDLE;
								end
							end
						end
					end
					SRP_AACK: begin
						// Count 0: eighth clock still high, line must stay free
						if (scl_fall && bit_cnt_q == 4'h0) begin
							bit_cnt_q <= 4'h1; // Low phase, ack goes out
						end else if (scl_rise && bit_cnt_q == 4'h1) begin
							bit_cnt_q <= 4'h2; // Ninth pulse high
						end else if (scl_fall && bit_cnt_q == 4'h2) begin
							// Ninth clock ends on its falling edge
							bit_cnt_q <= 4'h0;
							addr_phase_q <= 1'b0;
							if (addr_phase_q && rd_q) begin
								state_q <= SRP_RDAT;
							end else if (addr_phase_q) begin
								state_q <= SRP_SUBA;
							end else begin
								state_q <= SRP_WDAT;
							end
						end
					end
					SRP_RDAT: begin
						if (scl_fall) begin
							bit_cnt_q <= bit_cnt_q + 4'h1;
							if (bit_cnt_q == 4'h7) begin
								bit_cnt_q <= 4'h0;
								state_q <= SRP_RACK; // release for ack
							end
						end
					end
					SRP_RACK: begin
						if (scl_rise && sda) begin
							// Master nack ends the read
							state_q <= SRP_IDLE;
						end else if (scl_fall) begin
							// Acked: next byte starts as the ninth clock falls
							state_q <= SRP_RDAT;
							bit_cnt_q <= 4'h0;
						end
					end
					default: begin
						state_q <= SRP_IDLE;
					end
				endcase
			end
			// Pointer steps after each stored write byte and each acked read byte, pinning at the end for reads
			if (!start_c && !stop_c) begin
				if (state_q == SRP_WDAT && scl_rise && bit_cnt_q == 4'h7
					&& ptr_q <= `SRP_LAST_REG) begin
					ptr_q <= ptr_q + 6'h01;
				end else if (state_q == SRP_RACK && scl_rise && !sda
					&& ptr_q < `SRP_LAST_REG) begin
					ptr_q <= ptr_q + 6'h01;
				end
			end
		end
	end

	// Transmit shifter: load on entry to a read byte, shift on clock fall
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			tx_q <= 8'hFF;
		end else if ((state_q == SRP_AACK && addr_phase_q && rd_q && scl_fall && bit_cnt_q == 4'h2)
			|| (state_q == SRP_RACK && scl_fall)) begin
			tx_q <= rdata;
		end else if (state_q == SRP_RDAT && scl_fall) begin
			tx_q <= {tx_q[6:0], 1'b1};
		end
	end

	// Open-drain drive: only pull low or release
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_serial_data_line_oe <= 1'b0;
		end else if (state_q == SRP_AACK && bit_cnt_q != 4'h0 && !start_c && !stop_c) begin
			o_serial_data_line_oe <= 1'b1;
		end else if (state_q == SRP_RDAT && !start_c && !stop_c) begin
			o_serial_data_line_oe <= !tx_q[7];
		end else begin
			o_serial_data_line_oe <= 1'b0;
		end
	end

	// Constant low drive level, registered
	always_ff @(posedge i_clk) begin
		o_serial_data_line_out <= 1'b0;
	end

	// Mode outputs straight from flops
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_pedestal_enable <= 1'b1;
			o_output_standard <= `SRP_STD_NTSC;
			o_low_pixel_input_byte_sel <= 1'b1;
		end else begin
			o_pedestal_enable <= ped_en;
			o_output_standard <= std_sel;
			o_low_pixel_input_byte_sel <= 1'b1;
		end
	end

	srp_regfile u_regs (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_we(we_q),
		.i_waddr(ptr_q - 6'h01),
		.i_wdata(shift_q),
		.i_raddr(ptr_q),
		.o_rdata(rdata),
		.o_ped_en(ped_en),
		.o_std(std_sel)
	);

	// Acknowledge drive held across the ninth pulse
	a_ack_driven: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(state_q == SRP_AACK && scl_rise) |=> o_serial_data_line_oe)
		else $error("ack not driven");
	a_stop_idle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(stop_c && !start_c) |=> state_q == SRP_IDLE)
		else $error("stop did not idle");
	a_start_addr: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		start_c |=> state_q == SRP_ADDR && bit_cnt_q == 4'h0)
		else $error("start not taken");
	a_idle_release: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(state_q == SRP_IDLE) [*2] |-> !o_serial_data_line_oe)
		else $error("idle drives bus");
	a_ptr_bound: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		state_q == SRP_RDAT |-> ptr_q <= `SRP_LAST_REG)
		else $error("read pointer past end");
	a_write_bound: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		we_q |-> ptr_q >= 6'h01 && ptr_q <= `SRP_NUM_REGS)
		else $error("write past end");
	a_drive_low: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		o_serial_data_line_oe |-> !o_serial_data_line_out)
		else $error("drove high");
	a_ped_reset: assert property (@(posedge i_clk)
		$fell(i_rst_n) |=> ##1 o_pedestal_enable)
		else $error("pedestal not set on reset");

	// Byte-end steps shared by the checks below; a bus edge never meets start or stop
	sequence s_addr_byte_end;
		state_q == SRP_ADDR && scl_rise && bit_cnt_q == 4'h7 && !start_c && !stop_c;
	endsequence
	sequence s_sub_byte_end;
		state_q == SRP_SUBA && scl_rise && bit_cnt_q == 4'h7 && !start_c && !stop_c;
	endsequence
	sequence s_write_byte_end;
		state_q == SRP_WDAT && scl_rise && bit_cnt_q == 4'h7 && !start_c && !stop_c;
	endsequence
	sequence s_read_acked;
		state_q == SRP_RACK && scl_rise && !sda;
	endsequence

	// Own address: ack phase entered, direction bit kept
	a_addr_dir: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_addr_byte_end ##0 (rx_byte[7:1] == {`SRP_ADDR_HI, strap_q})
		|=> state_q == SRP_AACK && rd_q == $past(rx_byte[0]))
		else $error("own address not taken");
	// Foreign address: back to idle, line left alone
	a_addr_miss: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_addr_byte_end ##0 (rx_byte[7:1] != {`SRP_ADDR_HI, strap_q})
		|=> state_q == SRP_IDLE)
		else $error("foreign address answered");
	// Valid second byte becomes the pointer
	a_sub_load: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_sub_byte_end ##0 idx_ok(rx_byte)
		|=> ptr_q == $past(rx_byte[5:0]) && state_q == SRP_AACK)
		else $error("pointer not loaded");
	// Bad pointer byte: no ack phase at all
	a_sub_refuse: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_sub_byte_end ##0 !idx_ok(rx_byte)
		|=> state_q == SRP_IDLE)
		else $error("bad pointer accepted");
	// Each stored byte writes once and steps the pointer
	a_ptr_step: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_write_byte_end ##0 (ptr_q <= `SRP_LAST_REG)
		|=> we_q && ptr_q == $past(ptr_q) + 6'h01)
		else $error("write did not step");
	// Byte beyond the map: dropped, no ack, idle
	a_write_end: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_write_byte_end ##0 (ptr_q > `SRP_LAST_REG)
		|=> !we_q && state_q == SRP_IDLE)
		else $error("overrun byte kept");

	// Acked read byte moves on unless at the top
	a_read_step: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_read_acked ##0 (ptr_q < `SRP_LAST_REG)
		|=> ptr_q == $past(ptr_q) + 6'h01)
		else $error("read did not step");
	a_read_pin: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_read_acked ##0 (ptr_q == `SRP_LAST_REG)
		|=> ptr_q == `SRP_LAST_REG && state_q == SRP_RACK)
		else $error("read pointer left the top");
	// Line free for the master's ack bit
	a_read_release: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		state_q == SRP_RACK |=> !o_serial_data_line_oe)
		else $error("ack bit driven by slave");
	// No pull while the eighth clock is still high, else a false start
	a_ack_window: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(state_q == SRP_AACK && bit_cnt_q == 4'h0) |=> !o_serial_data_line_oe)
		else $error("ack driven too early");
endmodule // srp_port
`default_nettype wire

// ### verification/srp_master.sv
// Bus master model driving the two-wire serial port of the design.
// Assumes an open-drain data wire with pull-up, resolved in the bench.
`default_nettype none
module srp_master (
	input wire logic i_clk,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda_low,
	output logic [7:0] o_res,
	output logic [15:0] o_res_cnt
);
	timeunit 1ns;
	timeprecision 1ps;
	// Third of a bit period in system clocks, well above the sync delay
	localparam int H = 16;
	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
		o_res = 8'h00;
		o_res_cnt = 16'h0000;
	end
	task automatic hw();
		repeat (H) @(negedge i_clk);
	endtask
	// Start: data falls while clock high, one per high period
	task automatic start();
		o_sda_low = 1'b0;
		hw();
		o_scl = 1'b1;
		hw();
		o_sda_low = 1'b1;
		hw();
		o_scl = 1'b0;
		hw();
	endtask
	task automatic stop();
		o_sda_low = 1'b1;
		hw();
		o_scl = 1'b1;
		hw();
		o_sda_low = 1'b0;
		hw();
	endtask
	// One bit: data set in clock low, sampled at end of clock high
	task automatic bitx(input logic b, output logic s);
		o_sda_low = !b;
		hw();
		o_scl = 1'b1;
		hw();
		s = i_sda;
		o_scl = 1'b0;
		hw();
	endtask
	task automatic rep(input logic [7:0] v);
		o_res = v;
		o_res_cnt++;
	endtask
	// Fewer than eight bits leaves a byte cut short
	task automatic wbyte(input logic [7:0] b, input int nb);
		logic s;
		for (int i = 0; i < nb; i++) bitx(b[7-i], s);
		if (nb == 8) begin
			bitx(1'b1, s);
			rep({7'h00, s});
		end
	endtask
	// Last byte of a read gets no acknowledge
	task automatic rbyte(input logic last);
		logic s;
		logic [7:0] v;
		for (int i = 0; i < 8; i++) begin
			bitx(1'b1, s);
			v = {v[6:0], s};
		end
		rep(v);
		bitx(last, s);
	endtask
endmodule // srp_master
`default_nettype wire

// ### verification/srp_port_tb.sv
// Self-checking bench for the serial register port, master model at the pins.
// Assumes the design constants header on the include path.
`default_nettype none
`include "srp_cfg.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
	$display("CHECK FAILED %s exp %0h got %0h", n, e, g); errors++; end end
module srp_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import srp_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, strap = 1'b0, oe, dout, ped, lowsel, scl, sda_low, sda;
	logic [1:0] std;
	logic [7:0] res;
	logic [15:0] res_cnt;
	int errors = 0, total_checks = 0;
	srp_byte_t exp_q[$], d[$];
	string nm_q[$];
	// Open-drain wire, pulled up when nobody pulls low
	assign sda = (oe || sda_low) ? 1'b0 : 1'b1;
	initial forever #2 clk = !clk;
	srp_port uut (.i_clk(clk), .i_rst_n(rst_n), .i_serial_clock_line(scl),
		.i_serial_data_line(sda), .i_address_select_pin(strap),
		.o_serial_data_line_oe(oe), .o_serial_data_line_out(dout),
		.o_pedestal_enable(ped), .o_output_standard(std),
		.o_low_pixel_input_byte_sel(lowsel));
	srp_master m (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low),
		.o_res(res), .o_res_cnt(res_cnt));
	task automatic ex(input string n, input srp_byte_t v);
		nm_q.push_back(n);
		exp_q.push_back(v);
	endtask
	// Oldest note is matched against each result from the master
	always @(res_cnt) begin : watch
		string n;
		srp_byte_t e;
		if (exp_q.size() > 0) begin
			n = nm_q.pop_front();
			e = exp_q.pop_front();
			`CHK(n, e, res)
		end else if (res_cnt != 16'h0000) begin
			// A result nobody asked for is a fault too
			$display("CHECK FAILED unexpected result exp none got %0h", res);
			errors++;
		end
	end
	function automatic srp_byte_t ad(input logic rw);
		return {`SRP_ADDR_HI, strap, rw};
	endfunction
	// The first byte after the ok ones is refused and ends the transfer; later bytes are not sent
	task automatic wr(input srp_byte_t b[$], input int ok);
		m.start();
		foreach (b[i]) begin
			ex("ack", (i < ok) ? 8'h00 : 8'h01);
			m.wbyte(b[i], 8);
			if (i >= ok) break;
		end
		m.stop();
	endtask
	task automatic rd(input srp_byte_t sub, input srp_byte_t e[$]);
		wr({ad(0), sub}, 2);
		m.start();
		ex("read ack", 8'h00);
		m.wbyte(ad(1), 8);
		foreach (e[i]) begin
			ex("read data", e[i]);
			m.rbyte(i == e.size() - 1);
		end
		m.stop();
	endtask
	task automatic conclude();
		if (exp_q.size() != 0) errors++; // Answers still owed
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		#300000;
		errors++;
		conclude();
	end
	initial begin
		void'($urandom(32'h42aeb524));
		strap = 1'($urandom);
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		repeat (8) @(negedge clk);
		`CHK("pedestal", 1'b1, ped)
		`CHK("standard", `SRP_STD_NTSC, std)
		`CHK("low pixel", 1'b1, lowsel)
		rd(8'h00, {8'h00});
		rd(8'h04, {`SRP_PED_RESET});
		rd(8'h0E, {8'h16, 8'h7C, 8'hF0, 8'h21});
		$display("test defaults done");
		// Random frequency burst written then read back
		for (int i = 0; i < 6; i++) d.push_back(8'($urandom));
		wr({ad(0), 8'h0E, d[0], d[1], d[2], d[3]}, 6);
		rd(8'h0E, {d[0], d[1], d[2], d[3]});
		// Write past the end, then read past it
		wr({ad(0), 8'h2E, d[4], d[5], 8'hA5}, 4);
		rd(8'h2E, {d[4], d[5], d[5], d[5]});
		wr({ad(0), 8'h04, 8'h00}, 3);
		repeat (4) @(negedge clk);
		`CHK("pedestal off", 1'b0, ped)
		$display("test bursts done");
		// Refusals: other strap, missing register, top pointer bits
		wr({ad(0) ^ 8'h02, 8'h04}, 0);
		wr({ad(0), 8'h30}, 1);
		wr({ad(0), 8'h44}, 1);
		// Stop inside a data byte drops it
		m.start();
		ex("ack", 8'h00);
		m.wbyte(ad(0), 8);
		ex("ack", 8'h00);
		m.wbyte(8'h04, 8);
		m.wbyte(8'hFF, 3);
		m.stop();
		rd(8'h04, {8'h00});
		`CHK("data out", 1'b0, dout)
		$display("test refusals done");
		// Reset again mid-run: defaults must come back
		rst_n = 1'b0;
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		repeat (8) @(negedge clk);
		`CHK("pedestal reset", 1'b1, ped)
		rd(8'h04, {`SRP_PED_RESET});
		$display("test reset done");
		conclude();
	end
endmodule // srp_port_tb
`default_nettype wire
